/* src/tcm_timer.sv */
// Two-channel timer with mode, compare, output level and output enable control
// What this block does
// - Channel 1 split bit clear counts 16 bits, set counts 8 bits.
// - Trigger code zero: software start only, hardware triggers ignored.
// - Trigger code one: selected input edge starts and captures.
// - Trigger code two: both input edges start and capture.
// - Trigger code four: slave takes master interrupt; other codes forbidden.
// - Edge code 00 picks falling edge, 01 picks rising edge.
// - Edge codes 10 and 11 both react to both edges.
// - Mode 0000 interval without start interrupt, 0001 with one.
// - Mode 0100/0101 capture without/with start interrupt; 0110 event counter.
// - Mode 1000 one-count ignores retrigger; 1001 accepts retrigger.
// - Mode 1100 capture plus one-count; other mode codes forbidden.
// - Output level bit sets the pin level; bit n serves channel n.
// - Output disabled: counter leaves level alone, software writes drive it.
// - Output enabled: software level writes ignored, timer drives level.
// - Output enabled: pin shows the square wave or pulse of the timer.
// - Clock source bit picks prescaled clock or input valid edge.
// - Clock select 00,01,10,11 picks prescaled clock a,c,b,d.
// - Writing start bit sets enable status and enables counting.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tcm_defines.svh"

module tcm_timer #(
	parameter int PRE_W = 16
) (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic TIMER_INPUT_PIN_0,
	input wire logic TIMER_INPUT_PIN_1,
	output logic [1:0] TIMER_OUT,
	output logic [1:0] TIMER_INT
);
	import tcm_pkg::*;

	// ************************************************
	// Elaboration check
	// ************************************************
	if (PRE_W < 16 || PRE_W > 31) begin : g_chk
		$error("PRE_W must lie between 16 and 31");
	end

	// ************************************************
	// Shared state
	// ************************************************
	logic [15:0] mode [2];
	logic [15:0] cmp [2];
	logic [15:0] cnt [2];
	logic en [2];
	logic lvl [2];
	logic irq [2];
	logic pin_d [2];
	logic [1:0] pin;
	logic [1:0] toe;
	logic [15:0] pre_sel;
	logic [PRE_W-1:0] pre_cnt;
	logic [3:0] pre_en;

	assign pin = {TIMER_INPUT_PIN_1, TIMER_INPUT_PIN_0};

	// ************************************************
	// Prescaler
	// ************************************************
	// Free-running divider, four taps chosen by 4-bit exponents
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			pre_cnt <= '0;
		end else begin
			pre_cnt <= pre_cnt + PRE_W'(1);
		end
	end

	// Tap k pulses once every 2**exponent cycles
	always_comb begin
		logic [PRE_W-1:0] m;
		m = '0;
		for (int k = 0; k < 4; k++) begin
			m = PRE_W'((32'h1 << pre_sel[k*`TCM_PRE_FIELD_W +: `TCM_PRE_FIELD_W]) - 32'h1);
			pre_en[k] = &(pre_cnt | ~m);
		end
	end

	// ************************************************
	// Shared control registers
	// ************************************************
	// Output enables and prescaler selection
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			toe <= 2'h0;
			pre_sel <= `TCM_RST16;
		end else if (WR) begin
			if (ADDR == `TCM_A_OE) begin
				toe <= WDATA[1:0];
			end
			if (ADDR == `TCM_A_PRE) begin
				pre_sel <= WDATA;
			end
		end
	end

	// ************************************************
	// Channels
	// ************************************************
	for (genvar i = 0; i < 2; i++) begin : g_ch
		logic rise, fall, valid, hw_trig, tick, split, master, start, stop;
		logic [1:0] ck;
		logic [15:0] cmask, load, wmask;
		logic [3:0] a_mode, a_cmp;
		tcm_mode_t md;
		tcm_trig_t trg;
		tcm_state_t st;

		assign a_mode = (i == 0) ? `TCM_A_MODE0 : `TCM_A_MODE1;
		assign a_cmp = (i == 0) ? `TCM_A_CMP0 : `TCM_A_CMP1;
		assign wmask = (i == 0) ? `TCM_MODE0_WMASK : `TCM_MODE1_WMASK;
		assign split = (i == 1) && mode[i][`TCM_F_SPLIT];
		assign cmask = split ? `TCM_MASK8 : `TCM_MASK16;
		assign load = cmp[i] & cmask;
		assign md = tcm_mode_t'(mode[i][`TCM_F_MD_HI:`TCM_F_MD_LO]);
		assign trg = tcm_trig_t'(mode[i][`TCM_F_STS_HI:`TCM_F_STS_LO]);
		assign master = (i == 0) ? 1'b0 : irq[0];
		assign rise = pin[i] & ~pin_d[i];
		assign fall = ~pin[i] & pin_d[i];
		assign start = WR && (ADDR == `TCM_A_START) && WDATA[i];
		assign stop = WR && (ADDR == `TCM_A_STOP) && WDATA[i];
		assign ck = {mode[i][`TCM_F_CKS_LO], mode[i][`TCM_F_CKS_HI]};

		// Valid edge of the channel input
		always_comb begin
			if (mode[i][`TCM_F_CIS_HI]) begin
				valid = rise | fall;
			end else if (mode[i][`TCM_F_CIS_LO]) begin
				valid = rise;
			end else begin
				valid = fall;
			end
		end

		// Hardware start or capture trigger
		always_comb begin
			case (trg)
				TCM_TRG_SW: hw_trig = 1'b0;
				TCM_TRG_EDGE: hw_trig = valid;
				TCM_TRG_BOTH: hw_trig = rise | fall;
				TCM_TRG_MASTER: hw_trig = master;
				default: hw_trig = 1'b0;
			endcase
		end

		// Count clock: prescaled tap or input edge
		always_comb begin
			if (md == TCM_MD_EVT || mode[i][`TCM_F_CCS]) begin
				tick = valid;
			end else begin
				tick = pre_en[ck];
			end
		end

		// Input edge history
		always_ff @(posedge REF_CLK) begin
			if (!RSTN) begin
				pin_d[i] <= 1'b0;
			end else begin
				pin_d[i] <= pin[i];
			end
		end

		// Mode register
		always_ff @(posedge REF_CLK) begin
			if (!RSTN) begin
				mode[i] <= `TCM_RST16;
			end else if (WR && ADDR == a_mode) begin
				mode[i] <= WDATA & wmask;
			end
		end

		// Compare register; capture beats a software write
		always_ff @(posedge REF_CLK) begin
			if (!RSTN) begin
				cmp[i] <= `TCM_RST16;
			end else if (st == TCM_RUN && hw_trig &&
				(md == TCM_MD_CAP || md == TCM_MD_CAP_SI || md == TCM_MD_CAPONE)) begin
				cmp[i] <= cnt[i];
			end else if (WR && ADDR == a_cmp) begin
				cmp[i] <= WDATA;
			end
		end

		// Sequencer, counter, interrupt and output level
		always_ff @(posedge REF_CLK) begin
			if (!RSTN) begin
				st <= TCM_IDLE;
				en[i] <= 1'b0;
				cnt[i] <= `TCM_RST16;
				irq[i] <= 1'b0;
				lvl[i] <= 1'b0;
			end else begin
				irq[i] <= 1'b0;
				if (!toe[i] && WR && ADDR == `TCM_A_LVL) begin
					lvl[i] <= WDATA[i];
				end
				if (stop) begin
					st <= TCM_IDLE;
					en[i] <= 1'b0;
				end else begin
					case (st)
						TCM_IDLE: begin
							if (start) begin
								en[i] <= 1'b1;
								case (md)
									TCM_MD_INT, TCM_MD_INT_SI, TCM_MD_EVT: begin
										cnt[i] <= load;
										irq[i] <= md[0];
										st <= TCM_RUN;
									end
									TCM_MD_CAP, TCM_MD_CAP_SI: begin
										cnt[i] <= `TCM_RST16;
										irq[i] <= md[0];
										st <= TCM_RUN;
									end
									TCM_MD_ONE, TCM_MD_ONE_RT, TCM_MD_CAPONE: begin
										st <= TCM_WAIT;
									end
									default: begin
										st <= TCM_IDLE;
									end
								endcase
							end
						end
						TCM_WAIT: begin
							if (hw_trig || start) begin
								st <= TCM_RUN;
								if (md == TCM_MD_CAPONE) begin
									cnt[i] <= `TCM_RST16;
								end else begin
									cnt[i] <= load;
									if (toe[i]) begin
										lvl[i] <= 1'b1;
									end
								end
							end
						end
						TCM_RUN: begin
							case (md)
								TCM_MD_INT, TCM_MD_INT_SI, TCM_MD_EVT: begin
									if (start) begin
										cnt[i] <= load;
									end else if (tick) begin
										if (cnt[i] == `TCM_RST16) begin
											cnt[i] <= load;
											irq[i] <= 1'b1;
											if (toe[i]) begin
												lvl[i] <= ~lvl[i];
											end
										end else begin
											cnt[i] <= cnt[i] - 16'h1;
										end
									end
								end
								TCM_MD_CAP, TCM_MD_CAP_SI: begin
									if (hw_trig) begin
										cnt[i] <= `TCM_RST16;
										irq[i] <= 1'b1;
									end else if (tick) begin
										cnt[i] <= (cnt[i] + 16'h1) & cmask;
									end
								end
								TCM_MD_ONE, TCM_MD_ONE_RT: begin
									if ((hw_trig || start) && md == TCM_MD_ONE_RT) begin
										cnt[i] <= load;
									end else if (tick) begin
										if (cnt[i] == `TCM_RST16) begin
											irq[i] <= 1'b1;
											st <= TCM_WAIT;
											if (toe[i]) begin
												lvl[i] <= 1'b0;
											end
										end else begin
											cnt[i] <= cnt[i] - 16'h1;
										end
									end
								end
								TCM_MD_CAPONE: begin
									if (hw_trig) begin
										irq[i] <= 1'b1;
										st <= TCM_WAIT;
									end else if (tick) begin
										cnt[i] <= (cnt[i] + 16'h1) & cmask;
									end
								end
								default: begin
									st <= TCM_IDLE;
								end
							endcase
						end
						default: begin
							st <= TCM_IDLE;
						end
					endcase
				end
			end
		end

		assign TIMER_OUT[i] = lvl[i];
		assign TIMER_INT[i] = irq[i];
	end

	// ************************************************
	// Read port
	// ************************************************
	// Read data stand for the one cycle after the strobe
	always_ff @(posedge REF_CLK) begin
		if (!RSTN || !RD) begin
			RDATA <= 16'h0000;
		end else begin
			case (ADDR)
				`TCM_A_MODE0: RDATA <= mode[0];
				`TCM_A_MODE1: RDATA <= mode[1];
				`TCM_A_CMP0: RDATA <= cmp[0];
				`TCM_A_CMP1: RDATA <= cmp[1];
				`TCM_A_LVL: RDATA <= {14'h0000, lvl[1], lvl[0]};
				`TCM_A_OE: RDATA <= {14'h0000, toe};
				`TCM_A_EN: RDATA <= {14'h0000, en[1], en[0]};
				`TCM_A_PRE: RDATA <= pre_sel;
				`TCM_A_CNT0: RDATA <= cnt[0];
				`TCM_A_CNT1: RDATA <= cnt[1];
				default: RDATA <= 16'h0000;
			endcase
		end
	end
endmodule // tcm_timer
`default_nettype wire

/* src/tcm_defines.svh */
// Register indices, field positions, masks and reset values of the timer channel pair
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH
// ************************************************
// Register indices
// ************************************************
`define TCM_A_MODE0 4'h0
`define TCM_A_MODE1 4'h1
`define TCM_A_CMP0 4'h2
`define TCM_A_CMP1 4'h3
`define TCM_A_LVL 4'h4
`define TCM_A_OE 4'h5
`define TCM_A_START 4'h6
`define TCM_A_STOP 4'h7
`define TCM_A_EN 4'h8
`define TCM_A_PRE 4'h9
`define TCM_A_CNT0 4'hA
`define TCM_A_CNT1 4'hB
// ************************************************
// Mode register fields
// ************************************************
`define TCM_F_CKS_HI 15
`define TCM_F_CKS_LO 14
`define TCM_F_CCS 12
`define TCM_F_SPLIT 11
`define TCM_F_STS_HI 10
`define TCM_F_STS_LO 8
`define TCM_F_CIS_HI 7
`define TCM_F_CIS_LO 6
`define TCM_F_MD_HI 3
`define TCM_F_MD_LO 0
// ************************************************
// Masks and reset values
// ************************************************
`define TCM_MODE1_WMASK 16'hDFCF
`define TCM_MODE0_WMASK 16'hD7CF
`define TCM_MASK8 16'h00FF
`define TCM_MASK16 16'hFFFF
`define TCM_RST16 16'h0000
`define TCM_PRE_FIELD_W 4
`endif

/* src/tcm_pkg.sv */
// Types shared by the timer channel pair
package tcm_pkg;
	// Channel sequencer states
	typedef enum logic [2:0] {
		TCM_IDLE = 3'b001,
		TCM_WAIT = 3'b010,
		TCM_RUN = 3'b100
	} tcm_state_t;
	// Operation mode codes
	typedef enum logic [3:0] {
		TCM_MD_INT = 4'h0,
		TCM_MD_INT_SI = 4'h1,
		TCM_MD_CAP = 4'h4,
		TCM_MD_CAP_SI = 4'h5,
		TCM_MD_EVT = 4'h6,
		TCM_MD_ONE = 4'h8,
		TCM_MD_ONE_RT = 4'h9,
		TCM_MD_CAPONE = 4'hC
	} tcm_mode_t;
	// Start and capture trigger sources
	typedef enum logic [2:0] {
		TCM_TRG_SW = 3'h0,
		TCM_TRG_EDGE = 3'h1,
		TCM_TRG_BOTH = 3'h2,
		TCM_TRG_MASTER = 3'h4
	} tcm_trig_t;
endpackage

/* tb/tcm_timer_asserts.sv */
// Port checks for the timer channel pair
`timescale 1ns/1ps
`default_nettype none
`include "tcm_defines.svh"
module tcm_timer_chk #(
	parameter int PRE_W = 16
) (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic TIMER_INPUT_PIN_0,
	input wire logic TIMER_INPUT_PIN_1,
	input wire logic [1:0] TIMER_OUT,
	input wire logic [1:0] TIMER_INT
);
	logic [15:0] mode1;
	logic [3:0] md0;
	logic [1:0] oe;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	// Shadow of software-written fields
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			mode1 <= 16'h0000;
			md0 <= 4'h0;
			oe <= 2'h0;
		end else if (WR) begin
			if (ADDR == `TCM_A_MODE1) mode1 <= WDATA & `TCM_MODE1_WMASK;
			if (ADDR == `TCM_A_MODE0) md0 <= WDATA[3:0];
			if (ADDR == `TCM_A_OE) oe <= WDATA[1:0];
		end
	end
	// ****************
	// Assertions
	// ****************
	AST_RST_OUT: assert property (!$past(RSTN) |-> TIMER_OUT == 2'h0 && TIMER_INT == 2'h0)
		else $error("outputs not cleared after reset");
	AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
		else $error("read data outside read slot");
	AST_LVL_WR: assert property (WR && ADDR == `TCM_A_LVL && !oe[0] |=> TIMER_OUT[0] == $past(WDATA[0]))
		else $error("level write not driven");
	AST_OUT_HOLD: assert property (!oe[0] && !(WR && ADDR == `TCM_A_LVL) |=> $stable(TIMER_OUT[0]))
		else $error("disabled output moved");
	AST_START_INT: assert property (WR && ADDR == `TCM_A_START && WDATA[0] && (md0 == 4'h1 || md0 == 4'h5)
		|=> TIMER_INT[0])
		else $error("start interrupt missing");
	AST_MODE_RB: assert property (RD && ADDR == `TCM_A_MODE1 |=> RDATA == $past(mode1))
		else $error("mode read back wrong");
	AST_OE_RB: assert property (RD && ADDR == `TCM_A_OE |=> RDATA == {14'h0000, $past(oe)})
		else $error("enable read back wrong");
	AST_LVL_RB: assert property (RD && ADDR == `TCM_A_LVL |=> RDATA == {14'h0000, $past(TIMER_OUT)})
		else $error("level read back wrong");
	// Main scenarios reached
	cover property (TIMER_INT[0] && TIMER_OUT[0]);
	cover property (WR && ADDR == `TCM_A_START);
	cover property (TIMER_INT[1]);
endmodule // tcm_timer_chk
bind tcm_timer tcm_timer_chk #(.PRE_W(PRE_W)) tcm_timer_chk_inst (.REF_CLK(REF_CLK), .RSTN(RSTN),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.TIMER_INPUT_PIN_0(TIMER_INPUT_PIN_0), .TIMER_INPUT_PIN_1(TIMER_INPUT_PIN_1),
	.TIMER_OUT(TIMER_OUT), .TIMER_INT(TIMER_INT));
`default_nettype wire

/* tb/tcm_pins_model.sv */
// Board-side model of the timer input pins
`timescale 1ns/1ps
`default_nettype none
module tcm_pins_model (
	input wire logic ref_clk,
	input wire logic [1:0] want,
	input wire logic slow,
	output logic [1:0] pin
);
	logic [1:0] d1;
	logic [1:0] d2;
	// Quiet low pins at start
	initial begin
		pin = 2'h0;
		d1 = 2'h0;
		d2 = 2'h0;
	end
	// Pins follow the request one or three cycles late
	always @(posedge ref_clk) begin
		d1 <= want;
		d2 <= d1;
		pin <= slow ? d2 : want;
	end
endmodule // tcm_pins_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the timer channel pair
`timescale 1ns/1ps
`default_nettype none
`include "tcm_defines.svh"
module tb;
	logic ref_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000, rdata;
	logic [1:0] want = 2'h0, pin, tout, tint;
	int n_mismatch = 0, checked = 0, cyc = 0, k, i;
	int nint [2] = '{0, 0}, last [2] = '{0, 0}, per [2] = '{0, 0};
	logic [15:0] row [11] = '{16'h0148, 16'h0044, 16'h0104, 16'h0144, 16'h0184, 16'h01C4,
		16'h0204, 16'h0045, 16'h018C, 16'h0288, 16'h0289};
	int ex [11] = '{1, 0, 1, 1, 2, 2, 2, 1, 1, 1, 0};
	tcm_timer tcm_timer_inst (.REF_CLK(ref_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .TIMER_INPUT_PIN_0(pin[0]),
		.TIMER_INPUT_PIN_1(pin[1]), .TIMER_OUT(tout), .TIMER_INT(tint));
	tcm_pins_model tcm_pins_model_inst (.ref_clk(ref_clk), .want(want), .slow(slow), .pin(pin));
	// ****************
	// Bus tasks
	// ****************
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
		#1;
	endtask
	task rd_reg(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task end_of_test;
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Clock, 4 ns period
	initial forever #2 ref_clk = ~ref_clk;
	// Interrupt counts and spacing per channel
	always @(posedge ref_clk) begin
		cyc++;
		for (int c = 0; c < 2; c++) begin
			if (tint[c] === 1'b1) begin
				per[c] = cyc - last[c];
				last[c] = cyc;
				nint[c]++;
			end
		end
	end
	// Run needs about 2200 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		end_of_test;
	end
	// ****************
	// Scenarios
	// ****************
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		for (i = 0; i < 9; i++) rd_reg(i[3:0], 16'h0000);
		wr_reg(`TCM_A_MODE0, 16'hFFFF);
		rd_reg(`TCM_A_MODE0, `TCM_MODE0_WMASK);
		wr_reg(`TCM_A_MODE1, 16'hFFFF);
		rd_reg(`TCM_A_MODE1, `TCM_MODE1_WMASK);
		wr_reg(4'hF, 16'hFFFF);
		rd_reg(4'hF, 16'h0000);
		// Interval on channel 0 driving its pin
		wr_reg(`TCM_A_LVL, 16'h0002);
		chk({14'h0000, tout}, 16'h0002);
		wr_reg(`TCM_A_CMP0, 16'h0270);
		wr_reg(`TCM_A_OE, 16'h0001);
		wr_reg(`TCM_A_MODE0, 16'h0001);
		wr_reg(`TCM_A_START, 16'h0001);
		rd_reg(`TCM_A_EN, 16'h0001);
		chk(16'(nint[0]), 16'h0001);
		repeat (700) @(posedge ref_clk);
		#1;
		chk({14'h0000, tout}, 16'h0003);
		wr_reg(`TCM_A_LVL, 16'h0002);
		rd_reg(`TCM_A_LVL, 16'h0003);
		repeat (600) @(posedge ref_clk);
		#1;
		chk(16'(per[0]), 16'h0271);
		chk({14'h0000, tout}, 16'h0002);
		wr_reg(`TCM_A_STOP, 16'h0001);
		rd_reg(`TCM_A_EN, 16'h0000);
		// Split channel 1, output left to software
		wr_reg(`TCM_A_CMP1, 16'hF423);
		rd_reg(`TCM_A_CMP1, 16'hF423);
		wr_reg(`TCM_A_MODE1, 16'h0800);
		wr_reg(`TCM_A_START, 16'h0002);
		repeat (100) @(posedge ref_clk);
		#1;
		chk(16'(per[1]), 16'h0024);
		chk({14'h0000, tout}, 16'h0002);
		wr_reg(`TCM_A_STOP, 16'h0002);
		// Pin-triggered one-count and capture, trigger codes zero, one and two, each edge code
		// Last two rows count long so the falling edge lands mid-count
		for (i = 0; i < 11; i++) begin
			wr_reg(`TCM_A_STOP, 16'h0001);
			wr_reg(`TCM_A_CMP0, (i > 8) ? 16'h0014 : 16'h0003);
			wr_reg(`TCM_A_MODE0, row[i]);
			wr_reg(`TCM_A_START, 16'h0001);
			slow <= i[0];
			k = nint[0];
			want <= 2'h1;
			repeat (16) @(posedge ref_clk);
			want <= 2'h0;
			repeat (16) @(posedge ref_clk);
			#1;
			chk(16'(nint[0] - k), 16'(ex[i]));
		end
		// Prescaler taps and master-triggered slave channel
		wr_reg(`TCM_A_STOP, 16'h0001);
		wr_reg(`TCM_A_PRE, 16'h3210);
		rd_reg(`TCM_A_PRE, 16'h3210);
		wr_reg(`TCM_A_CMP0, 16'h0003);
		wr_reg(`TCM_A_MODE1, 16'h0404);
		wr_reg(`TCM_A_START, 16'h0002);
		for (i = 0; i < 2; i++) begin
			wr_reg(`TCM_A_STOP, 16'h0001);
			wr_reg(`TCM_A_MODE0, i[0] ? 16'h8000 : 16'h4000);
			wr_reg(`TCM_A_START, 16'h0001);
			repeat (60) @(posedge ref_clk);
			#1;
			chk(16'(per[0]), i[0] ? 16'h0008 : 16'h0010);
			chk(16'(per[1]), i[0] ? 16'h0008 : 16'h0010);
		end
		// Input edges as count clock, then event counter
		wr_reg(`TCM_A_STOP, 16'h0003);
		wr_reg(`TCM_A_CMP0, 16'h0001);
		slow <= 1'b0;
		for (i = 0; i < 2; i++) begin
			wr_reg(`TCM_A_STOP, 16'h0001);
			wr_reg(`TCM_A_MODE0, i[0] ? 16'h0046 : 16'h1040);
			wr_reg(`TCM_A_START, 16'h0001);
			k = nint[0];
			repeat (4) begin
				want <= 2'h1;
				repeat (8) @(posedge ref_clk);
				want <= 2'h0;
				repeat (8) @(posedge ref_clk);
			end
			#1;
			chk(16'(nint[0] - k), 16'h0002);
		end
		rd_reg(`TCM_A_CNT0, 16'h0001);
		end_of_test;
	end
endmodule // tb
`default_nettype wire
